/* File: cel_cfg.svh */
// Constants of the camera experiment serial link: timing, offsets, codes, resets
`ifndef CEL_CFG_SVH
`define CEL_CFG_SVH

// ****************************************
// Serial timing
// ****************************************
`define CEL_CLK_HZ 20000000
`define CEL_BAUD_BPS 38400
`define CEL_BIT_CYC ((`CEL_CLK_HZ + (`CEL_BAUD_BPS / 2)) / `CEL_BAUD_BPS)
`define CEL_HALF_CYC (`CEL_BIT_CYC / 2)
`define CEL_GAP_BITS 20
`define CEL_DATA_BITS 4'h8
`define CEL_LAST_BIT 4'h7
`define CEL_STOP_SLOT 4'h9

// ****************************************
// Register byte addresses
// ****************************************
`define CEL_OFS_CTRL 8'h00
`define CEL_OFS_IDENT 8'h04
`define CEL_OFS_DESC 8'h08
`define CEL_OFS_STATUS 8'h0c
`define CEL_OFS_BUF_ADDR 8'h10
`define CEL_OFS_BUF_DATA 8'h14

// ****************************************
// Control fields and camera states
// ****************************************
`define CEL_CTRL_EN 0
`define CEL_CTRL_ST_LO 1
`define CEL_CTRL_ST_HI 2
`define CEL_CAM_NOT_READY 2'h0
`define CEL_CAM_READY 2'h1
`define CEL_CAM_FAILED 2'h2

// ****************************************
// Reset values
// ****************************************
`define CEL_RST_VERSION 16'h0078
`define CEL_RST_BUILD 16'h0001
`define CEL_RST_DESC 16'h0401

// ****************************************
// Message layout and codes
// ****************************************
`define CEL_READINESS_QUERY_CODE 16'h5252
`define CEL_TRANSMIT_BLOCK_CODE 16'h5454
`define CEL_NOT_READY_CODE 16'h4e4e
`define CEL_CAMERA_READY_CODE 16'h5959
`define CEL_CAMERA_FAILED_CODE 16'h4646
`define CEL_CMD_LAST 3'h5
`define CEL_REPLY_BYTES 11'h006
`define CEL_DATA_OVERHEAD 11'h008
`define CEL_PAYLOAD_START 11'h006
`define CEL_DESC_LEN_HI 9
`define CEL_DESC_LINE_LO 10
`define CEL_BUF_WORDS 1024

`endif

/* File: cel_pkg.sv */
// Types of the camera experiment serial link
package cel_pkg;

  typedef enum logic [1:0] {
    CEL_RX_IDLE,
    CEL_RX_START,
    CEL_RX_DATA,
    CEL_RX_STOP
  } cel_rx_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic ena;
    logic [1:0] cam;
    logic [15:0] version;
    logic [15:0] build;
    logic [15:0] desc;
    logic [9:0] wptr;
    logic [7:0] ok_cnt;
    logic [7:0] bad_cnt;
    logic [7:0] blk_cnt;
    logic s1;
    logic s2;
    logic s3;
    logic rx_lvl;
    logic p1;
    logic p2;
    logic p3;
    logic pwr_lvl;
    cel_rx_state_t rx_st;
    logic [9:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic [2:0] rx_nbytes;
    logic [47:0] rx_msg;
    logic rx_bad;
    logic [15:0] gap;
    logic msg_data;
    logic [15:0] msg_code;
    logic [15:0] msg_desc;
    logic [10:0] msg_idx;
    logic [10:0] msg_len;
    logic [15:0] sum;
    logic tx_busy;
    logic [9:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic tx_line;
  } cel_state_t;

endpackage

/* File: cel_camera_link.sv */
// Camera experiment side of the housekeeping serial link, with Avalon-MM registers
//
// Notes on behaviour
// - Camera sends exactly one reply message per accepted request.
// - Multi-byte fields and bits travel least significant first.
// - Invalid or malformed controller messages cause no action at all; the code still counts them in bad_cnt.
// - Each message is a header plus one command, reply or data block.
// - Link runs at 38400 bit/s, eight data bits, one stop, no parity.
// - Header holds 2-byte version then 2-byte build, both nonzero.
// - Version equals interface version with the decimal point dropped.
// - Build equals originator software build with points dropped.
// - Command block is one 2-byte code: readiness query or transmit.
// - Reply block is one 2-byte code: not ready, ready or failed.
// - Descriptor: upper 6 bits line number, lower 10 bits payload count.
// - Data block with a wrong checksum is an invalid message.
// - Message whose header version differs from ours is invalid.
`include "cel_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module cel_camera_link
  import cel_pkg::*;
#(
  parameter int BIT_CYCLES = `CEL_BIT_CYC,
  parameter int GAP_CYCLES = `CEL_GAP_BITS * BIT_CYCLES
) (
  input wire logic clk,
  input wire logic clk_en,
  input wire logic sys_rst,
  input wire logic power_en,
  input wire logic uart_rx,
  output logic uart_tx,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // Bit time is a parameter so a bench may run the link fast; must not exceed 1024
  localparam logic [9:0] BIT_LAST = 10'(BIT_CYCLES - 1);
  localparam logic [9:0] HALF_CYC = 10'(BIT_CYCLES / 2);
  localparam logic [15:0] GAP_LIMIT = 16'(GAP_CYCLES);

  cel_state_t st_r;
  cel_state_t st_nxt;
  logic [7:0] pay_mem [`CEL_BUF_WORDS];
  logic mem_we;
  logic [9:0] pay_a;
  logic [7:0] pay_byte;

  assign pay_a = 10'(st_r.msg_idx - `CEL_PAYLOAD_START);
  assign pay_byte = pay_mem[pay_a];
  assign avs_waitrequest = (avs_read | avs_write) & ~st_r.ack;
  assign avs_readdata = st_r.rdata;
  assign uart_tx = st_r.tx_line;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic byte_done;
    logic busy;
    logic valid;
    logic [47:0] msg;
    logic [15:0] cmd;
    logic [7:0] tb;
    logic [10:0] idx;
    byte_done = 1'b0;
    valid = 1'b0;
    msg = '0;
    cmd = '0;
    tb = '0;
    idx = st_r.msg_idx;
    mem_we = 1'b0;
    st_nxt = st_r;
    busy = (st_r.msg_idx != st_r.msg_len) | st_r.tx_busy;

    // Bus slave: one wait cycle; read data is latched at the edge that raises ack, writes land at the edge that ends the ack cycle
    st_nxt.ack = (avs_read | avs_write) & ~st_r.ack;
    if (avs_read & ~st_r.ack) begin
      case (avs_address)
        `CEL_OFS_CTRL: st_nxt.rdata = {29'h0, st_r.cam, st_r.ena};
        `CEL_OFS_IDENT: st_nxt.rdata = {st_r.build, st_r.version};
        `CEL_OFS_DESC: st_nxt.rdata = {16'h0, st_r.desc};
        `CEL_OFS_STATUS: st_nxt.rdata = {6'h0, st_r.pwr_lvl, busy, st_r.blk_cnt,
                                         st_r.bad_cnt, st_r.ok_cnt};
        `CEL_OFS_BUF_ADDR: st_nxt.rdata = {22'h0, st_r.wptr};
        default: st_nxt.rdata = 32'h0;
      endcase
    end
    if (avs_write & st_r.ack) begin
      case (avs_address)
        `CEL_OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            st_nxt.ena = avs_writedata[`CEL_CTRL_EN];
            st_nxt.cam = avs_writedata[`CEL_CTRL_ST_HI:`CEL_CTRL_ST_LO];
          end
        end
        `CEL_OFS_IDENT: begin
          st_nxt.version = merge16(st_r.version, avs_writedata[15:0], avs_byteenable[1:0]);
          st_nxt.build = merge16(st_r.build, avs_writedata[31:16], avs_byteenable[3:2]);
        end
        `CEL_OFS_DESC: begin
          st_nxt.desc = merge16(st_r.desc, avs_writedata[15:0], avs_byteenable[1:0]);
        end
        `CEL_OFS_BUF_ADDR: begin
          st_nxt.wptr = 10'(merge16({6'h0, st_r.wptr}, avs_writedata[15:0],
                                    avs_byteenable[1:0]));
        end
        `CEL_OFS_BUF_DATA: begin
          if (avs_byteenable[0]) begin
            mem_we = 1'b1;
            st_nxt.wptr = st_r.wptr + 10'h001;
          end
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // Receive path
    // ****************************************
    // Pin synchronisers; a level counts once the second and third stage agree
    st_nxt.s1 = uart_rx;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.rx_lvl = st_r.s3;
    end
    st_nxt.p1 = power_en;
    st_nxt.p2 = st_r.p1;
    st_nxt.p3 = st_r.p2;
    if (st_r.p2 == st_r.p3) begin
      st_nxt.pwr_lvl = st_r.p3;
    end

    // Character receiver, sampled mid-bit
    case (st_r.rx_st)
      CEL_RX_IDLE: begin
        if (!st_r.rx_lvl) begin
          st_nxt.rx_st = CEL_RX_START;
          st_nxt.rx_cnt = HALF_CYC;
        end
      end
      CEL_RX_START: begin
        if (st_r.rx_cnt == 10'h000) begin
          // A start bit gone high by mid-bit was a glitch
          st_nxt.rx_st = st_r.rx_lvl ? CEL_RX_IDLE : CEL_RX_DATA;
          st_nxt.rx_cnt = BIT_LAST;
          st_nxt.rx_bit = 4'h0;
        end else begin
          st_nxt.rx_cnt = st_r.rx_cnt - 10'h001;
        end
      end
      CEL_RX_DATA: begin
        if (st_r.rx_cnt == 10'h000) begin
          st_nxt.rx_sh = {st_r.rx_lvl, st_r.rx_sh[7:1]};
          st_nxt.rx_cnt = BIT_LAST;
          st_nxt.rx_bit = st_r.rx_bit + 4'h1;
          if (st_r.rx_bit == `CEL_LAST_BIT) begin
            st_nxt.rx_st = CEL_RX_STOP;
          end
        end else begin
          st_nxt.rx_cnt = st_r.rx_cnt - 10'h001;
        end
      end
      CEL_RX_STOP: begin
        if (st_r.rx_cnt == 10'h000) begin
          byte_done = 1'b1;
          st_nxt.rx_st = CEL_RX_IDLE;
        end else begin
          st_nxt.rx_cnt = st_r.rx_cnt - 10'h001;
        end
      end
      default: begin
        st_nxt.rx_st = CEL_RX_IDLE;
      end
    endcase

    // A long silence inside a message drops the partial message
    if (st_r.rx_st != CEL_RX_IDLE || st_r.rx_nbytes == 3'h0) begin
      st_nxt.gap = 16'h0;
    end else if (st_r.gap != GAP_LIMIT) begin
      st_nxt.gap = st_r.gap + 16'h0001;
    end else begin
      st_nxt.gap = 16'h0;
      st_nxt.rx_nbytes = 3'h0;
      st_nxt.rx_bad = 1'b0;
      st_nxt.bad_cnt = st_r.bad_cnt + 8'h01;
    end

    // Command message: header then one command block
    if (byte_done) begin
      msg = {st_r.rx_sh, st_r.rx_msg[47:8]};
      st_nxt.rx_msg = msg;
      st_nxt.rx_bad = st_r.rx_bad | ~st_r.rx_lvl;
      st_nxt.rx_nbytes = st_r.rx_nbytes + 3'h1;
      if (st_r.rx_nbytes == `CEL_CMD_LAST) begin
        st_nxt.rx_nbytes = 3'h0;
        st_nxt.rx_bad = 1'b0;
        cmd = msg[47:32];
        // Bad framing, foreign version, zero build or unknown code: stay silent
        valid = ~st_r.rx_bad & st_r.rx_lvl & ~busy & st_r.ena
              & (msg[15:0] == st_r.version)
              & (msg[31:16] != 16'h0)
              & ((cmd == `CEL_READINESS_QUERY_CODE) | (cmd == `CEL_TRANSMIT_BLOCK_CODE));
        if (!valid) begin
          st_nxt.bad_cnt = st_r.bad_cnt + 8'h01;
        end else begin
          st_nxt.ok_cnt = st_r.ok_cnt + 8'h01;
          st_nxt.msg_idx = 11'h000;
          st_nxt.sum = 16'h0;
          st_nxt.msg_desc = st_r.desc;
          if (cmd == `CEL_TRANSMIT_BLOCK_CODE && st_r.cam == `CEL_CAM_READY) begin
            st_nxt.msg_data = 1'b1;
            st_nxt.msg_len = 11'(st_r.desc[`CEL_DESC_LEN_HI:0]) + `CEL_DATA_OVERHEAD;
            st_nxt.blk_cnt = st_r.blk_cnt + 8'h01;
          end else begin
            st_nxt.msg_data = 1'b0;
            st_nxt.msg_len = `CEL_REPLY_BYTES;
            if (st_r.cam == `CEL_CAM_FAILED) begin
              st_nxt.msg_code = `CEL_CAMERA_FAILED_CODE;
            end else if (st_r.cam == `CEL_CAM_READY) begin
              st_nxt.msg_code = `CEL_CAMERA_READY_CODE;
            end else begin
              st_nxt.msg_code = `CEL_NOT_READY_CODE;
            end
          end
        end
      end
    end

    // Unpowered or disabled: nothing is parsed
    if (!st_r.pwr_lvl || !st_r.ena) begin
      st_nxt.rx_nbytes = 3'h0;
      st_nxt.rx_bad = 1'b0;
    end

    // ****************************************
    // Transmit path
    // ****************************************
    // Message builder feeding the character transmitter
    if (!st_r.tx_busy) begin
      if (st_r.msg_idx != st_r.msg_len) begin
        if (idx < 11'h004) begin
          case (idx[1:0])
            2'h0: tb = st_r.version[7:0];
            2'h1: tb = st_r.version[15:8];
            2'h2: tb = st_r.build[7:0];
            default: tb = st_r.build[15:8];
          endcase
          st_nxt.sum = st_r.sum + 16'(tb);
        end else if (idx < `CEL_PAYLOAD_START) begin
          if (st_r.msg_data) begin
            tb = idx[0] ? st_r.msg_desc[15:8] : st_r.msg_desc[7:0];
          end else begin
            tb = idx[0] ? st_r.msg_code[15:8] : st_r.msg_code[7:0];
          end
        end else if (idx < st_r.msg_len - 11'h002) begin
          tb = pay_byte;
          st_nxt.sum = st_r.sum + 16'(tb);
        end else begin
          tb = idx == st_r.msg_len - 11'h002 ? st_r.sum[7:0] : st_r.sum[15:8];
        end
        st_nxt.msg_idx = st_r.msg_idx + 11'h001;
        st_nxt.tx_sh = {1'b1, tb, 1'b0};
        st_nxt.tx_line = 1'b0;
        st_nxt.tx_busy = 1'b1;
        st_nxt.tx_cnt = BIT_LAST;
        st_nxt.tx_bit = 4'h0;
      end
    end else if (st_r.tx_cnt != 10'h000) begin
      st_nxt.tx_cnt = st_r.tx_cnt - 10'h001;
    end else if (st_r.tx_bit == `CEL_STOP_SLOT) begin
      st_nxt.tx_busy = 1'b0;
      st_nxt.tx_line = 1'b1;
    end else begin
      st_nxt.tx_sh = {1'b1, st_r.tx_sh[9:1]};
      st_nxt.tx_line = st_r.tx_sh[1];
      st_nxt.tx_bit = st_r.tx_bit + 4'h1;
      st_nxt.tx_cnt = BIT_LAST;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.version <= `CEL_RST_VERSION;
      st_r.build <= `CEL_RST_BUILD;
      st_r.desc <= `CEL_RST_DESC;
      st_r.s1 <= 1'b1;
      st_r.s2 <= 1'b1;
      st_r.s3 <= 1'b1;
      st_r.rx_lvl <= 1'b1;
      st_r.tx_line <= 1'b1;
      st_r.rx_st <= CEL_RX_IDLE;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // Payload store has no reset; software fills it before use
  always_ff @(posedge clk) begin
    if (clk_en && mem_we) begin
      pay_mem[st_r.wptr] <= avs_writedata[7:0];
    end
  end

endmodule

`default_nettype wire

/* File: cel_props.sv */
// Port-level checks of the camera link
`include "cel_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cel_props #(
  parameter int BIT_C = `CEL_BIT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic uart_tx,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  localparam int LOW_MAX = 9 * BIT_C;
  logic [15:0] lo_cnt;
  // Length of the current low run on the serial output
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lo_cnt <= 16'h0000;
    end else if (!uart_tx) begin
      lo_cnt <= lo_cnt + 16'h0001;
    end else begin
      lo_cnt <= 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_req;
    avs_read || avs_write;
  endsequence
  sequence s_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    (avs_read || avs_write) && !avs_waitrequest;
  endsequence
  property p_wait_one;
    s_wait |=> !avs_waitrequest;
  endproperty
  property p_ack_one;
    s_ack ##1 s_req |-> avs_waitrequest;
  endproperty
  property p_idle_nowait;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  property p_tx_rst_idle;
    @(posedge clk) disable iff (1'b0) sys_rst |-> uart_tx;
  endproperty
  property p_low_mult;
    $rose(uart_tx) |-> (lo_cnt % BIT_C) == 0;
  endproperty
  property p_low_max;
    !uart_tx |-> lo_cnt < LOW_MAX;
  endproperty
  property p_rdata_hold;
    !avs_read |=> $stable(avs_readdata);
  endproperty
  property p_unmapped_zero;
    s_ack ##0 (avs_read && avs_address > `CEL_OFS_BUF_DATA) |-> avs_readdata == 32'h0;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  a_idle_nowait: assert property (p_idle_nowait) else $error("wait without request");
  a_tx_rst_idle: assert property (p_tx_rst_idle) else $error("tx low in reset");
  a_low_mult: assert property (p_low_mult) else $error("low run off bit grid");
  a_low_max: assert property (p_low_max) else $error("stop bit missing");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* File: cel_hk_model.sv */
// Behavioural housekeeping controller on the serial side
`include "cel_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cel_hk_model #(
  parameter int BIT_C = `CEL_BIT_CYC
) (
  input wire logic clk,
  input wire logic cam_tx,
  output logic cam_rx,
  output logic [7:0] got_byte,
  output logic got_stop,
  output logic got_stb
);
  initial begin
    cam_rx = 1'b1;
    got_byte = 8'h00;
    got_stop = 1'b0;
    got_stb = 1'b0;
  end
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      cam_rx <= fr[i];
      repeat (BIT_C) @(posedge clk);
    end
  endtask
  task automatic send_msg(input logic [15:0] ver, input logic [15:0] bld,
                          input logic [15:0] code);
    logic [47:0] m;
    m = {code, bld, ver};
    for (int i = 0; i < 6; i++) begin
      send_byte(m[8*i +: 8]);
    end
  endtask
  // Samples mid-bit; stop level is handed on for the bench to judge
  initial begin
    forever begin
      @(posedge clk);
      got_stb <= 1'b0;
      if (cam_tx === 1'b0) begin
        repeat (BIT_C / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_C) @(posedge clk);
          got_byte[i] <= cam_tx;
        end
        repeat (BIT_C) @(posedge clk);
        got_stop <= cam_tx;
        got_stb <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the camera link
`include "cel_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int BIT_C = 32;
  localparam int GAP_C = 2000;
  // Power-up wait shortened with the bit time to keep the run short
  localparam int PWR_C = 2000;
  localparam logic [15:0] VER = `CEL_RST_VERSION;
  localparam logic [15:0] BLD = `CEL_RST_BUILD;
  logic clk = 1'b0;
  logic sys_rst = 1'b0;
  logic power_en = 1'b0;
  logic uart_rx;
  logic uart_tx;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] got_byte;
  logic got_stop;
  logic got_stb;
  logic [7:0] exp_q[$];
  logic [31:0] rd;
  logic [7:0] pl [3];
  logic [15:0] sum;
  int err_total = 0;
  int total_checks = 0;
  int seed = 92;
  cel_camera_link #(.BIT_CYCLES(BIT_C), .GAP_CYCLES(GAP_C)) i_dut (.clk(clk), .clk_en(1'b1),
    .sys_rst(sys_rst), .power_en(power_en), .uart_rx(uart_rx), .uart_tx(uart_tx),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  cel_hk_model #(.BIT_C(BIT_C)) i_hk (.clk(clk), .cam_tx(uart_tx), .cam_rx(uart_rx),
    .got_byte(got_byte), .got_stop(got_stop), .got_stb(got_stb));
  initial begin
    forever #25 clk = ~clk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done();
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic push16(input logic [15:0] v);
    exp_q.push_back(v[7:0]);
    exp_q.push_back(v[15:8]);
  endtask
  task automatic exp_reply(input logic [15:0] code);
    push16(VER);
    push16(BLD);
    push16(code);
  endtask
  // Gives a late reply time to show, then insists nothing is owed
  task automatic settle();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 200000) begin
      @(posedge clk);
      n++;
    end
    repeat (12 * BIT_C) @(posedge clk);
    chk("pending bytes", 32'h0, 32'(exp_q.size()));
  endtask
  always @(posedge clk) begin
    if (got_stb === 1'b1) begin
      chk("stop bit", 32'h1, {31'h0, got_stop});
      if (exp_q.size() == 0) begin
        chk("unexpected byte", 32'h100, {24'h0, got_byte});
      end else begin
        chk("reply byte", {24'h0, exp_q.pop_front()}, {24'h0, got_byte});
      end
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, `CEL_OFS_IDENT, 32'h0);
    chk("IDENT", {BLD, VER}, rd);
    bus(1'b0, `CEL_OFS_DESC, 32'h0);
    chk("DESC", {16'h0, `CEL_RST_DESC}, rd);
    bus(1'b0, `CEL_OFS_CTRL, 32'h0);
    chk("CTRL", 32'h0, rd);
    bus(1'b1, `CEL_OFS_STATUS, 32'hffffffff);
    bus(1'b0, `CEL_OFS_STATUS, 32'h0);
    chk("STATUS", 32'h0, rd);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    power_en <= 1'b1;
    repeat (PWR_C) @(posedge clk);
    bus(1'b1, `CEL_OFS_CTRL, 32'h1);
    exp_reply(`CEL_NOT_READY_CODE);
    i_hk.send_msg(VER, BLD, `CEL_READINESS_QUERY_CODE);
    settle();
    i_hk.send_msg(VER - 16'h1, BLD, `CEL_READINESS_QUERY_CODE);
    settle();
    i_hk.send_msg(VER, BLD, 16'h5858);
    settle();
    for (int s = 2; s > 0; s--) begin
      bus(1'b1, `CEL_OFS_CTRL, {29'h0, s[1:0], 1'b1});
      exp_reply(s == 2 ? `CEL_CAMERA_FAILED_CODE : `CEL_CAMERA_READY_CODE);
      i_hk.send_msg(VER, BLD, `CEL_READINESS_QUERY_CODE);
      settle();
    end
    bus(1'b1, `CEL_OFS_BUF_ADDR, 32'h0);
    sum = VER[7:0] + VER[15:8] + BLD[7:0] + BLD[15:8];
    for (int i = 0; i < 3; i++) begin
      pl[i] = 8'($random(seed));
      sum = sum + pl[i];
      bus(1'b1, `CEL_OFS_BUF_DATA, {24'h0, pl[i]});
    end
    // Bottom picture line with three bytes of payload
    bus(1'b1, `CEL_OFS_DESC, 32'h0000f003);
    push16(VER);
    push16(BLD);
    push16(16'hf003);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(pl[i]);
    end
    push16(sum);
    i_hk.send_msg(VER, BLD, `CEL_TRANSMIT_BLOCK_CODE);
    settle();
    bus(1'b0, `CEL_OFS_STATUS, 32'h0);
    chk("STATUS", 32'h02010204, rd);
    test_done();
  end
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    $display("ERROR watchdog expected done seen timeout");
    test_done();
  end
endmodule
bind cel_camera_link cel_props #(.BIT_C(BIT_CYCLES)) i_props (.clk, .sys_rst, .uart_tx,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest);
`default_nettype wire
